// ===== anmc_map.vh
// Register map, strap codes and timing macros for the mode config block
`ifndef ANMC_MAP_VH
`define ANMC_MAP_VH
// Register indices, byte address is four times the index
`define ANMC_IDX_CTRL      6'h00
`define ANMC_IDX_ADV       6'h04
`define ANMC_IDX_PARTNER   6'h05
`define ANMC_IDX_STAT      6'h19
// Control fields
`define ANMC_CTRL_SWRST    15
`define ANMC_CTRL_SPEED    13
`define ANMC_CTRL_AN_EN    12
`define ANMC_CTRL_RESTART  9
`define ANMC_CTRL_DUPLEX   8
`define ANMC_CTRL_RST      16'h3000
`define ANMC_CTRL_WMASK    16'h3100
// Status fields
`define ANMC_STAT_AN       10
`define ANMC_STAT_FD       7
`define ANMC_STAT_S10      6
// Advertisement values
`define ANMC_ADV_10H       9'h021
`define ANMC_ADV_10F       9'h041
`define ANMC_ADV_100H      9'h081
`define ANMC_ADV_100F      9'h101
`define ANMC_ADV_ALL       9'h1e1
`define ANMC_ADV_100HF     9'h181
`define ANMC_ADV_100F10F   9'h141
`define ANMC_ADV_100H10H   9'h0a1
`define ANMC_ADV_10HF      9'h061
// Strap states
`define ANMC_S_L           2'h0
`define ANMC_S_H           2'h1
`define ANMC_S_M           2'h2
`define ANMC_S_C           2'h3
// Timing
`define ANMC_CLK_PERIOD_NS 4
`define ANMC_STRAP_WIN_NS  256
`define ANMC_CLK_EDGES     4'h4
`endif

// ===== anmc_top.v
// Strap decode, mode control registers and operating mode resolution
`timescale 1ns/100ps
`include "anmc_map.vh"

module anmc_top (
   input  wire        pclk,           // APB clock, 250 MHz
   input  wire        presetn,        // Async reset, active low
   input  wire        psel,           // APB select
   input  wire        penable,        // APB enable
   input  wire [7:0]  paddr,          // APB byte address
   input  wire        pwrite,         // APB write
   input  wire [31:0] pwdata,         // APB write data
   output reg  [31:0] prdata,         // APB read data
   output reg         pready,         // APB ready
   output reg         pslverr,        // APB error, unmapped address
   input  wire        strap_low_a,    // Low strap, upper comparator
   input  wire        strap_low_b,    // Low strap, lower comparator
   input  wire        strap_high_a,   // High strap, upper comparator
   input  wire        strap_high_b,   // High strap, lower comparator
   input  wire        neg_done,       // Negotiation complete level
   input  wire [15:0] partner_word,   // Received partner abilities
   output reg  [15:0] ability_advertisement, // Word for link bursts
   output reg         flp_enable,     // Send link bursts
   output reg         an_restart,     // Restart pulse to negotiation
   output reg         op_speed100,    // Operating speed is 100 Mb/s
   output reg         op_full_duplex, // Operating duplex is full
   output reg         strap_valid     // Straps captured
);

   localparam integer WIN_CYC =
      (`ANMC_STRAP_WIN_NS + `ANMC_CLK_PERIOD_NS - 1) / `ANMC_CLK_PERIOD_NS - 1;
   localparam [7:0] WIN_LAST = WIN_CYC[7:0];

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function [1:0] strap_state;
      input       a;
      input       b;
      input [3:0] edges;
      begin
         if (edges >= `ANMC_CLK_EDGES)
            strap_state = `ANMC_S_C;
         else if (a & b)
            strap_state = `ANMC_S_H;
         else if (b)
            strap_state = `ANMC_S_M;
         else
            strap_state = `ANMC_S_L;
      end
   endfunction

   // Returns {an_enable, speed10, full_duplex, adv[8:0]}
   function [11:0] strap_cfg;
      input [1:0] hi;
      input [1:0] lo;
      begin
         case ({hi, lo})
            {`ANMC_S_L, `ANMC_S_M}: strap_cfg = {3'h2, `ANMC_ADV_10H};
            {`ANMC_S_H, `ANMC_S_M}: strap_cfg = {3'h3, `ANMC_ADV_10F};
            {`ANMC_S_M, `ANMC_S_L}: strap_cfg = {3'h0, `ANMC_ADV_100H};
            {`ANMC_S_M, `ANMC_S_H}: strap_cfg = {3'h1, `ANMC_ADV_100F};
            {`ANMC_S_C, `ANMC_S_M}: strap_cfg = {3'h1, `ANMC_ADV_100HF};
            {`ANMC_S_M, `ANMC_S_C}: strap_cfg = {3'h1, `ANMC_ADV_100F10F};
            {`ANMC_S_C, `ANMC_S_C}: strap_cfg = {3'h0, `ANMC_ADV_100H10H};
            {`ANMC_S_M, `ANMC_S_M}: strap_cfg = {3'h4, `ANMC_ADV_ALL};
            {`ANMC_S_L, `ANMC_S_L}: strap_cfg = {3'h4, `ANMC_ADV_10H};
            {`ANMC_S_L, `ANMC_S_H}: strap_cfg = {3'h4, `ANMC_ADV_10F};
            {`ANMC_S_H, `ANMC_S_L}: strap_cfg = {3'h4, `ANMC_ADV_100H};
            {`ANMC_S_H, `ANMC_S_H}: strap_cfg = {3'h4, `ANMC_ADV_100F};
            {`ANMC_S_C, `ANMC_S_H}: strap_cfg = {3'h4, `ANMC_ADV_100F10F};
            {`ANMC_S_C, `ANMC_S_L}: strap_cfg = {3'h4, `ANMC_ADV_100H10H};
            {`ANMC_S_H, `ANMC_S_C}: strap_cfg = {3'h4, `ANMC_ADV_100HF};
            {`ANMC_S_L, `ANMC_S_C}: strap_cfg = {3'h4, `ANMC_ADV_10HF};
            default:                strap_cfg = {3'h4, `ANMC_ADV_ALL};
         endcase
      end
   endfunction

   // Returns {valid, speed100, full_duplex}
   function [2:0] resolve;
      input [3:0] common;
      begin
         if (common[3])
            resolve = 3'h7;
         else if (common[2])
            resolve = 3'h6;
         else if (common[1])
            resolve = 3'h5;
         else if (common[0])
            resolve = 3'h4;
         else
            resolve = 3'h0;
      end
   endfunction

   // Returns {hit, register code}
   function [2:0] reg_sel;
      input [7:0] addr;
      begin
         if (addr[1:0] != 2'h0)
            reg_sel = 3'h0;
         else begin
            case (addr[7:2])
               `ANMC_IDX_CTRL:    reg_sel = 3'h4;
               `ANMC_IDX_ADV:     reg_sel = 3'h5;
               `ANMC_IDX_PARTNER: reg_sel = 3'h6;
               `ANMC_IDX_STAT:    reg_sel = 3'h7;
               default:           reg_sel = 3'h0;
            endcase
         end
      end
   endfunction

   // ----------------------------------------
   // Strap synchronisers and clock detect
   // ----------------------------------------
   reg  [3:0]  sync1;
   reg  [3:0]  sync2;
   reg  [3:0]  sync3;
   reg  [3:0]  edges_lo;
   reg  [3:0]  edges_hi;
   reg  [7:0]  win_cnt;
   reg  [15:0] basic_mode_control;
   reg  [15:0] partner_ability;
   reg         override;
   reg         cfg_hold_s10;
   reg         cfg_hold_fd;
   reg         res_valid;
   reg         res_s100;
   reg         res_fd;
   reg         next_an;
   reg         next_s100;
   reg         next_fd;
   reg  [31:0] next_rd;

   wire [3:0]  strap_in = {strap_high_b, strap_high_a, strap_low_b, strap_low_a};
   wire        edge_lo  = sync2[0] ^ sync3[0];
   wire        edge_hi  = sync2[2] ^ sync3[2];
   wire [1:0]  st_lo    = strap_state(sync2[0], sync2[1], edges_lo);
   wire [1:0]  st_hi    = strap_state(sync2[2], sync2[3], edges_hi);
   wire [11:0] cfg_now  = strap_cfg(st_hi, st_lo);
   wire        strap_load = ~strap_valid & (win_cnt == WIN_LAST);
   wire        acc      = psel & penable;
   wire [2:0]  sel      = reg_sel(paddr);
   wire        wr_now   = acc & pready & pwrite;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
         sync3 <= 4'h0;
      end else begin
         sync1 <= strap_in;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // Observation window after release, then frozen until next reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win_cnt     <= 8'h00;
         edges_lo    <= 4'h0;
         edges_hi    <= 4'h0;
         strap_valid <= 1'b0;
      end else if (!strap_valid) begin
         win_cnt <= win_cnt + 8'h01;
         if (edge_lo && edges_lo != 4'hf)
            edges_lo <= edges_lo + 4'h1;
         if (edge_hi && edges_hi != 4'hf)
            edges_hi <= edges_hi + 4'h1;
         if (strap_load)
            strap_valid <= 1'b1;
      end
   end

   // ----------------------------------------
   // Operating mode
   // ----------------------------------------
   always @* begin
      if (override) begin
         next_an   = 1'b0;
         next_s100 = ~cfg_hold_s10;
         next_fd   = cfg_hold_fd;
      end else if (basic_mode_control[`ANMC_CTRL_AN_EN]) begin
         next_an   = 1'b1;
         next_s100 = res_valid & res_s100;
         next_fd   = res_valid & res_fd;
      end else begin
         next_an   = 1'b0;
         next_s100 = basic_mode_control[`ANMC_CTRL_SPEED];
         next_fd   = basic_mode_control[`ANMC_CTRL_DUPLEX];
      end
   end

   always @* begin
      next_rd = 32'h0000_0000;
      case (sel)
         3'h4: next_rd = {16'h0000, basic_mode_control};
         3'h5: next_rd = {16'h0000, ability_advertisement};
         3'h6: next_rd = {16'h0000, partner_ability};
         3'h7: begin
            next_rd[`ANMC_STAT_AN]  = flp_enable;
            next_rd[`ANMC_STAT_FD]  = op_full_duplex;
            next_rd[`ANMC_STAT_S10] = ~op_speed100;
         end
         default: next_rd = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------
   // Registers and APB slave
   // ----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         basic_mode_control    <= `ANMC_CTRL_RST;
         ability_advertisement <= {7'h00, `ANMC_ADV_ALL};
         partner_ability       <= 16'h0000;
         override              <= 1'b0;
         cfg_hold_s10          <= 1'b0;
         cfg_hold_fd           <= 1'b0;
         res_valid             <= 1'b0;
         res_s100              <= 1'b0;
         res_fd                <= 1'b0;
         an_restart            <= 1'b0;
         prdata                <= 32'h0000_0000;
         pready                <= 1'b0;
         pslverr               <= 1'b0;
         flp_enable            <= 1'b0;
         op_speed100           <= 1'b0;
         op_full_duplex        <= 1'b0;
      end else begin
         an_restart <= 1'b0;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         if (acc && !pready && strap_valid) begin
            pready  <= 1'b1;
            pslverr <= ~sel[2];
            prdata  <= next_rd;
         end
         if (wr_now && sel == 3'h4) begin
            if (pwdata[`ANMC_CTRL_SWRST]) begin
               basic_mode_control    <= `ANMC_CTRL_RST;
               ability_advertisement <= {7'h00, `ANMC_ADV_ALL};
               partner_ability       <= 16'h0000;
               override              <= 1'b0;
               res_valid             <= 1'b0;
            end else begin
               basic_mode_control <= pwdata[15:0] & `ANMC_CTRL_WMASK;
               if (!pwdata[`ANMC_CTRL_AN_EN])
                  override <= 1'b0;
               if (pwdata[`ANMC_CTRL_RESTART]) begin
                  an_restart <= 1'b1;
                  res_valid  <= 1'b0;
               end
            end
         end
         if (wr_now && sel == 3'h5)
            ability_advertisement <= pwdata[15:0];
         if (strap_load) begin
            ability_advertisement <= {7'h00, cfg_now[8:0]};
            override              <= ~cfg_now[11];
            cfg_hold_s10          <= cfg_now[10];
            cfg_hold_fd           <= cfg_now[9];
         end
         // Completion set placed last so it wins over a same-cycle clear
         if (neg_done && basic_mode_control[`ANMC_CTRL_AN_EN] && !override) begin
            partner_ability <= partner_word;
            {res_valid, res_s100, res_fd} <=
               resolve(ability_advertisement[8:5] & partner_word[8:5]);
         end
         flp_enable     <= next_an;
         op_speed100    <= next_s100;
         op_full_duplex <= next_fd;
      end
   end

endmodule // anmc_top

// ===== anmc_mode_asserts.sv
// Checker for bus handshake, restart pulse and strap hold
`timescale 1ns/100ps
module anmc_mode_asserts (
   input logic        pclk,                  // Clock
   input logic        presetn,               // Reset, active low
   input logic        psel,                  // Select
   input logic        penable,               // Enable
   input logic [7:0]  paddr,                 // Address
   input logic        pwrite,                // Direction
   input logic [31:0] pwdata,                // Write data
   input logic [31:0] prdata,                // Read data
   input logic        pready,                // Ready
   input logic        pslverr,               // Error
   input logic [15:0] ability_advertisement, // Advert
   input logic        an_restart,            // Restart pulse
   input logic        strap_valid            // Straps held
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   pready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
   ready_access_a: assert property (pready |-> $past(psel && penable))
      else $error("ready without access");
   access_answer_a: assert property (psel && penable && !pready && strap_valid |=> pready)
      else $error("access not answered");
   ready_valid_a: assert property (pready |-> strap_valid) else $error("answer before straps");
   slverr_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("bad error reply");
   restart_pulse_a: assert property (an_restart |=> !an_restart) else $error("restart long");
   restart_cause_a: assert property (an_restart |->
      $past(pready && psel && pwrite && paddr == 8'h00 && pwdata[9]))
      else $error("restart without write");
   strap_hold_a: assert property (strap_valid |=> strap_valid) else $error("straps lost");
   adv_hold_a: assert property (strap_valid && $past(strap_valid)
      && $changed(ability_advertisement) |-> $past(pready && psel && pwrite))
      else $error("advert changed alone");
endmodule // anmc_mode_asserts

// ===== anmc_partner.sv
// Negotiation engine and link partner model
`timescale 1ns/100ps
module anmc_partner (
   input  logic        pclk,         // Clock
   input  logic        presetn,      // Reset, active low
   input  logic        flp_enable,   // Bursts sent
   input  logic        an_restart,   // Restart pulse
   input  logic [15:0] word_in,      // Abilities to report
   input  logic [7:0]  delay,        // Cycles to complete
   output logic        neg_done,     // Completion level
   output logic [15:0] partner_word  // Partner abilities
);
   logic [7:0] cnt;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         neg_done <= 1'b0;
         cnt      <= 8'h00;
      end else if (!flp_enable || an_restart) begin
         neg_done <= 1'b0;
         cnt      <= delay;
      end else if (cnt != 8'h00) begin
         cnt <= cnt - 8'h01;
      end else begin
         neg_done <= 1'b1;
      end
   end
   // Junk word until complete
   assign partner_word = neg_done ? word_in : ~word_in;
endmodule // anmc_partner

// ===== autoneg_mode_config_tb.sv
// Self-checking bench for the mode config block
`timescale 1ns/100ps
module autoneg_mode_config_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, clk25;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        sla, slb, sha, shb, neg_done, flp_enable, an_restart;
   logic        op_speed100, op_full_duplex, strap_valid;
   logic [15:0] partner_word, ability_advertisement, word_in;
   logic [1:0]  st_hi, st_lo;
   logic [2:0]  div;
   int          n_fail, n_compared;
   // {enable, duplex, speed10, advert} per strap pair
   logic [11:0] tab [16] = '{12'h821, 12'h841, 12'h221, 12'h861, 12'h881, 12'h901,
      12'h641, 12'h981, 12'h081, 12'h501, 12'h9e1, 12'h541, 12'h8a1, 12'h941,
      12'h581, 12'h0a1};
   assign sla = (st_lo == 2'h3) ? clk25 : (st_lo == 2'h1);
   assign slb = (st_lo == 2'h3) ? clk25 : (st_lo != 2'h0);
   assign sha = (st_hi == 2'h3) ? clk25 : (st_hi == 2'h1);
   assign shb = (st_hi == 2'h3) ? clk25 : (st_hi != 2'h0);
   anmc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .paddr(paddr), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .strap_low_a(sla), .strap_low_b(slb), .strap_high_a(sha),
      .strap_high_b(shb), .neg_done(neg_done), .partner_word(partner_word),
      .ability_advertisement(ability_advertisement), .flp_enable(flp_enable),
      .an_restart(an_restart), .op_speed100(op_speed100),
      .op_full_duplex(op_full_duplex), .strap_valid(strap_valid));
   anmc_partner u_partner (.pclk(pclk), .presetn(presetn), .flp_enable(flp_enable),
      .an_restart(an_restart), .word_in(word_in), .delay(8'h0a), .neg_done(neg_done),
      .partner_word(partner_word));
   always @(posedge pclk) begin
      div <= (div == 3'h4) ? 3'h0 : div + 3'h1;
      if (div == 3'h4) clk25 <= ~clk25;
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      while (pready !== 1'b1 && n < 300) @(negedge pclk) n++;
      if (n >= 300) chk("apb_timeout", 1'b1, 1'b0);
      @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] v;
      logic        e;
      apb(1'b1, a, d, v, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      logic e;
      apb(1'b0, a, 32'h0, v, e);
   endtask
   task automatic do_reset(input logic [1:0] hi, input logic [1:0] lo);
      int n;
      n = 0;
      @(posedge pclk);
      presetn <= 1'b0;
      st_hi <= hi;
      st_lo <= lo;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      while (strap_valid !== 1'b1 && n < 200) @(posedge pclk) n++;
      chk("strap_valid", strap_valid, 1'b1);
   endtask
   task automatic t_straps();
      logic [31:0] v;
      for (int i = 0; i < 16; i++) begin
         do_reset(i[3:2], i[1:0]);
         rd(8'h10, v);
         chk("advert", v, {23'h0, tab[i][8:0]});
         rd(8'h64, v);
         chk("stat_an", v[10], tab[i][11]);
         if (!tab[i][11]) chk("stat_mode", v[7:6], tab[i][10:9]);
         rd(8'h00, v);
         chk("ctrl", v, 32'h3000);
         st_hi <= ~st_hi;
         repeat (80) @(posedge pclk);
         rd(8'h10, v);
         chk("advert_held", v, {23'h0, tab[i][8:0]});
      end
      $display("t_straps done");
   endtask
   task automatic t_negotiate();
      logic [31:0] v;
      int          n;
      logic [15:0] adv [6] = '{16'h1e1, 16'h1e1, 16'h1e1, 16'h1e1, 16'h041, 16'h1e1};
      logic [15:0] wd [6] = '{16'h1e1, 16'h0a1, 16'h061, 16'h021, 16'h1e1, 16'h000};
      logic [1:0]  sd [6] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h1, 2'h0};
      do_reset(2'h2, 2'h2);
      for (int i = 0; i < 6; i++) begin
         n = 0;
         wr(8'h10, {16'h0, adv[i]});
         word_in <= wd[i];
         wr(8'h00, 32'h1200);
         repeat (4) @(posedge pclk);
         while (neg_done !== 1'b1 && n < 300) @(posedge pclk) n++;
         chk("neg_done", neg_done, 1'b1);
         repeat (3) @(posedge pclk);
         chk("flp_enable", flp_enable, 1'b1);
         chk("op_mode", {op_speed100, op_full_duplex}, sd[i]);
         rd(8'h64, v);
         chk("stat_neg", {v[10], v[7], v[6]}, {1'b1, sd[i][0], ~sd[i][1]});
      end
      $display("t_negotiate done");
   endtask
   task automatic t_forced();
      logic [31:0] v;
      for (int i = 0; i < 4; i++) begin
         wr(8'h00, {18'h0, i[1], 4'h0, i[0], 8'h00});
         repeat (3) @(posedge pclk);
         chk("flp_off", flp_enable, 1'b0);
         chk("op_forced", {op_speed100, op_full_duplex}, i[1:0]);
         rd(8'h64, v);
         chk("stat_forced", {v[10], v[7], v[6]}, {1'b0, i[0], ~i[1]});
      end
      $display("t_forced done");
   endtask
   task automatic t_soft();
      logic [31:0] v;
      logic        e;
      do_reset(2'h2, 2'h0);
      wr(8'h00, 32'h1000);
      chk("flp_strap", flp_enable, 1'b0);
      wr(8'h00, 32'h0000);
      wr(8'h00, 32'h1000);
      repeat (3) @(posedge pclk);
      chk("flp_sw", flp_enable, 1'b1);
      wr(8'h10, 32'h0021);
      wr(8'h00, 32'h8000);
      rd(8'h00, v);
      chk("ctrl_soft", v, 32'h3000);
      rd(8'h10, v);
      chk("adv_soft", v, 32'h01e1);
      apb(1'b0, 8'h08, 32'h0, v, e);
      chk("unmapped_err", e, 1'b1);
      chk("unmapped_data", v, 32'h0);
      apb(1'b1, 8'h02, 32'h0, v, e);
      chk("misaligned", e, 1'b1);
      $display("t_soft done");
   endtask
   task automatic report_and_stop();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      #200000;
      n_fail++;
      report_and_stop();
   end
   initial begin
      {presetn, psel, penable, pwrite, clk25, paddr, pwdata, div} = '0;
      {st_hi, st_lo, word_in, n_fail, n_compared} = '0;
      t_straps();
      t_negotiate();
      t_forced();
      t_soft();
      report_and_stop();
   end
endmodule // autoneg_mode_config_tb
bind anmc_top anmc_mode_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .paddr(paddr), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .ability_advertisement(ability_advertisement),
   .an_restart(an_restart), .strap_valid(strap_valid));
